// ---- rtl/cis_pkg.sv ----
// shared constants and types for the core instruction subset block
package cis_pkg;

  // apb byte offsets
  localparam logic [7:0] CIS_OFF_CMD    = 8'h00;
  localparam logic [7:0] CIS_OFF_STATUS = 8'h04;
  localparam logic [7:0] CIS_OFF_WORK   = 8'h08;
  localparam logic [7:0] CIS_OFF_PC     = 8'h0c;
  localparam logic [7:0] CIS_OFF_LATCH  = 8'h10;
  localparam logic [7:0] CIS_OFF_STACK  = 8'h14;
  localparam logic [7:0] CIS_OFF_FADDR  = 8'h18;
  localparam logic [7:0] CIS_OFF_FDATA  = 8'h1c;
  localparam logic [7:0] CIS_OFF_WAKE   = 8'h20;

  // status word bit positions
  localparam int CIS_ST_BUSY  = 5;
  localparam int CIS_ST_SLEEP = 6;
  localparam int CIS_ST_SKIP  = 7;

  // widths and depth
  localparam int CIS_DW = 8;
  localparam int CIS_FAW = 7;
  localparam int CIS_DEPTH = 128;
  localparam int CIS_PCW = 13;
  localparam int CIS_KW = 11;
  localparam int CIS_LATHW = 5;

  // values after reset
  localparam logic [7:0]  CIS_RST_WORK   = 8'h00;
  localparam logic [12:0] CIS_RST_PC     = 13'h0000;
  localparam logic [4:0]  CIS_RST_LATCH  = 5'h00;
  localparam logic [6:0]  CIS_RST_FADDR  = 7'h00;
  localparam logic [4:0]  CIS_RST_FLAGS  = 5'h18;

  typedef enum logic [3:0] {
    CIS_NOP,
    CIS_SKIP_IF_BIT_SET_OP,
    CIS_WATCHDOG_CLEAR_OP,
    CIS_CALL_OP,
    CIS_COMPLEMENT_FILE_OP,
    CIS_CLEAR_FILE_OP,
    CIS_CLEAR_WORKING_OP,
    CIS_DECREMENT_FILE_OP,
    CIS_ROTATE_LEFT_CARRY_OP,
    CIS_ROTATE_RIGHT_CARRY_OP,
    CIS_SLEEP_OP,
    CIS_LITERAL_SUBTRACT_OP
  } cis_op_e;

  // command word as written to the command register
  typedef struct packed {
    logic [10:0] k;
    logic [6:0]  fAddr;
    logic [2:0]  bitSel;
    logic        dest;
    cis_op_e     op;
  } cis_cmd_s;

  // status flags, msb first, low five bits of status
  typedef struct packed {
    logic timeoutFlag;
    logic powerdownFlag;
    logic zeroFlag;
    logic digitCarryFlag;
    logic carryFlag;
  } cis_flags_s;

  localparam int CIS_CMD_W = $bits(cis_cmd_s);

endpackage : cis_pkg

// ---- rtl/cis_file_ram.sv ----
// file register memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module cis_file_ram
  import cis_pkg::*;
(
  // clock
  input  wire logic               ref_clk,
  // write port
  input  wire logic               we,
  input  wire logic [CIS_FAW-1:0] addr,
  input  wire logic [CIS_DW-1:0]  wdata,
  // read port
  output logic      [CIS_DW-1:0]  rdata_r
);

  logic [CIS_DW-1:0] mem [CIS_DEPTH];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    rdata_r <= mem[addr];
  end

endmodule : cis_file_ram
`default_nettype wire

// ---- rtl/cis_core.sv ----
// executes the instruction subset written over apb
// Functional notes
// (RULE1) bit-test skip: bit set discards next instruction, runs a no-op, flags unchanged
// (RULE2) watchdog clear zeroes watchdog and prescaler, sets timeout and powerdown flags
// (RULE3) call pushes pc plus one, loads 11-bit target, upper bits from latch 4:3
// (RULE4) complement inverts file register, result to working or file, zero updated
// (RULE5) clear file writes zero to file register and sets zero flag
// (RULE6) clear working writes zero to working register and sets zero flag
// (RULE7) decrement subtracts one, result to chosen destination, zero updated
// (RULE8) rotate left through carry: carry into bit 0, bit 7 out to carry
// (RULE9) rotate right through carry: carry into bit 7, bit 0 out to carry
// (RULE10) sleep clears watchdog, sets timeout, clears powerdown, halts with oscillator stopped
// (RULE11) literal minus working to working; carry and digit carry as no-borrow; zero updated
// (RULE12) all data eight bits; zero flag set exactly when stored result is zero; the rotates store a result but leave zero unchanged
`timescale 1ns/1ps
`default_nettype none
module cis_core
  import cis_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // watchdog and oscillator control
  output logic             watchdogClear,
  output logic             oscStop
);

  typedef enum logic [2:0] {
    CIS_IDLE,
    CIS_FETCH,
    CIS_EXEC,
    CIS_NOP2,
    CIS_SLEEP
  } cis_state_e;

  cis_state_e            state_r;
  cis_state_e            state_nxt;
  cis_cmd_s              cmd_r;
  cis_flags_s            flags_r;
  cis_flags_s            flags_nxt;
  logic [CIS_DW-1:0]     working_r;
  logic [CIS_DW-1:0]     working_nxt;
  logic [CIS_PCW-1:0]    pc_r;
  logic [CIS_PCW-1:0]    stackTop_r;
  logic [CIS_LATHW-1:0]  pcHighLatch_r;
  logic [CIS_FAW-1:0]    fileAddr_r;
  logic                  skipPending_r;
  logic                  discard_r;
  logic                  busy;
  logic                  busyD_r;
  logic                  ack_r;
  logic                  apbDo;
  logic                  apbWr;
  logic                  mapped;
  logic                  wdPulse_r;
  logic [31:0]           prdata_r;
  logic [31:0]           rdMux;
  logic                  ramWe;
  logic [CIS_FAW-1:0]    ramAddr;
  logic [CIS_DW-1:0]     ramWdata;
  logic [CIS_DW-1:0]     fileVal;
  logic [CIS_DW-1:0]     result;
  logic                  toFile;
  logic                  isSkipSet;
  logic [CIS_DW:0]       subDiff;

  // apb decode and handshake
  assign busy = (state_r != CIS_IDLE) && (state_r != CIS_SLEEP);
  assign mapped = (paddr == CIS_OFF_CMD) || (paddr == CIS_OFF_STATUS) ||
                  (paddr == CIS_OFF_WORK) || (paddr == CIS_OFF_PC) ||
                  (paddr == CIS_OFF_LATCH) || (paddr == CIS_OFF_STACK) ||
                  (paddr == CIS_OFF_FADDR) || (paddr == CIS_OFF_FDATA) ||
                  (paddr == CIS_OFF_WAKE);
  assign pready = ack_r;
  assign pslverr = ack_r && !mapped;
  assign prdata = prdata_r;
  assign apbDo = psel && penable && ack_r;
  assign apbWr = apbDo && pwrite && mapped;
  assign watchdogClear = wdPulse_r;
  assign oscStop = (state_r == CIS_SLEEP);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busyD_r <= 1'b0;
    end else begin
      busyD_r <= busy;
    end
  end

  // one wait state, held off while an instruction runs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= psel && penable && !ack_r && !busy && !busyD_r;
    end
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    case (paddr)
      CIS_OFF_CMD: rdMux[CIS_CMD_W-1:0] = cmd_r;
      CIS_OFF_STATUS: begin
        rdMux[$bits(cis_flags_s)-1:0] = flags_r;
        rdMux[CIS_ST_BUSY] = busy;
        rdMux[CIS_ST_SLEEP] = (state_r == CIS_SLEEP);
        rdMux[CIS_ST_SKIP] = skipPending_r;
      end
      CIS_OFF_WORK: rdMux[CIS_DW-1:0] = working_r;
      CIS_OFF_PC: rdMux[CIS_PCW-1:0] = pc_r;
      CIS_OFF_LATCH: rdMux[CIS_LATHW-1:0] = pcHighLatch_r;
      CIS_OFF_STACK: rdMux[CIS_PCW-1:0] = stackTop_r;
      CIS_OFF_FADDR: rdMux[CIS_FAW-1:0] = fileAddr_r;
      CIS_OFF_FDATA: rdMux[CIS_DW-1:0] = fileVal;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && penable && !ack_r && !pwrite) begin
      prdata_r <= rdMux;
    end
  end

  // file register memory
  assign ramAddr = busy ? cmd_r.fAddr : fileAddr_r;
  assign toFile = cmd_r.dest;

  cis_file_ram u_ram (
    .ref_clk (ref_clk),
    .we      (ramWe),
    .addr    (ramAddr),
    .wdata   (ramWdata),
    .rdata_r (fileVal)
  );

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fileAddr_r <= CIS_RST_FADDR;
    end else if (apbWr && paddr == CIS_OFF_FADDR) begin
      fileAddr_r <= pwdata[CIS_FAW-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pcHighLatch_r <= CIS_RST_LATCH;
    end else if (apbWr && paddr == CIS_OFF_LATCH) begin
      pcHighLatch_r <= pwdata[CIS_LATHW-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmd_r <= '0;
    end else if (apbWr && paddr == CIS_OFF_CMD && state_r == CIS_IDLE) begin
      cmd_r <= pwdata[CIS_CMD_W-1:0];
    end
  end

  assign isSkipSet = fileVal[cmd_r.bitSel];
  assign subDiff = {1'b0, cmd_r.k[CIS_DW-1:0]} - {1'b0, working_r};

  // datapath of the executing instruction
  always_comb begin
    result = fileVal;
    flags_nxt = flags_r;
    ramWe = 1'b0;
    ramWdata = pwdata[CIS_DW-1:0];
    working_nxt = working_r;
    if (state_r == CIS_EXEC) begin
      case (cmd_r.op)
        CIS_WATCHDOG_CLEAR_OP: begin
          // (RULE2) flags set
          flags_nxt.timeoutFlag = 1'b1;
          flags_nxt.powerdownFlag = 1'b1;
        end
        CIS_SLEEP_OP: begin
          // (RULE10) flags for sleep
          flags_nxt.timeoutFlag = 1'b1;
          flags_nxt.powerdownFlag = 1'b0;
        end
        CIS_COMPLEMENT_FILE_OP: begin
          // (RULE4) invert file
          result = ~fileVal;
          flags_nxt.zeroFlag = (result == 8'h00);
        end
        CIS_CLEAR_FILE_OP: begin
          // (RULE5) clear file
          result = 8'h00;
          flags_nxt.zeroFlag = 1'b1;
        end
        CIS_CLEAR_WORKING_OP: begin
          // (RULE6) clear working
          result = 8'h00;
          flags_nxt.zeroFlag = 1'b1;
        end
        CIS_DECREMENT_FILE_OP: begin
          // (RULE7) decrement file
          result = fileVal - 8'h01;
          // (RULE12) zero from result
          flags_nxt.zeroFlag = (result == 8'h00);
        end
        CIS_ROTATE_LEFT_CARRY_OP: begin
          // (RULE8) rotate left
          result = {fileVal[CIS_DW-2:0], flags_r.carryFlag};
          flags_nxt.carryFlag = fileVal[CIS_DW-1];
        end
        CIS_ROTATE_RIGHT_CARRY_OP: begin
          // (RULE9) rotate right
          result = {flags_r.carryFlag, fileVal[CIS_DW-1:1]};
          flags_nxt.carryFlag = fileVal[0];
        end
        CIS_LITERAL_SUBTRACT_OP: begin
          // (RULE11) literal minus working
          result = subDiff[CIS_DW-1:0];
          flags_nxt.carryFlag = (working_r <= cmd_r.k[CIS_DW-1:0]);
          flags_nxt.digitCarryFlag = (working_r[3:0] <= cmd_r.k[3:0]);
          flags_nxt.zeroFlag = (result == 8'h00);
        end
        default: result = fileVal;
      endcase
      case (cmd_r.op)
        CIS_CLEAR_FILE_OP: begin
          ramWe = 1'b1;
          ramWdata = result;
        end
        CIS_CLEAR_WORKING_OP, CIS_LITERAL_SUBTRACT_OP: working_nxt = result;
        CIS_COMPLEMENT_FILE_OP, CIS_DECREMENT_FILE_OP,
        CIS_ROTATE_LEFT_CARRY_OP, CIS_ROTATE_RIGHT_CARRY_OP: begin
          ramWe = toFile;
          ramWdata = result;
          if (!toFile) begin
            working_nxt = result;
          end
        end
        default: working_nxt = working_r;
      endcase
    end else if (state_r == CIS_IDLE && apbWr && paddr == CIS_OFF_FDATA) begin
      ramWe = 1'b1;
    end else if (state_r == CIS_IDLE && apbWr && paddr == CIS_OFF_WORK) begin
      working_nxt = pwdata[CIS_DW-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flags_r <= CIS_RST_FLAGS;
      working_r <= CIS_RST_WORK;
    end else begin
      flags_r <= flags_nxt;
      working_r <= working_nxt;
    end
  end

  // sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CIS_IDLE: begin
        if (apbWr && paddr == CIS_OFF_CMD) begin
          state_nxt = skipPending_r ? CIS_NOP2 : CIS_FETCH;
        end
      end
      CIS_FETCH: state_nxt = CIS_EXEC;
      CIS_EXEC: begin
        if (cmd_r.op == CIS_SLEEP_OP) begin
          state_nxt = CIS_SLEEP;
        end else if (cmd_r.op == CIS_CALL_OP) begin
          state_nxt = CIS_NOP2;
        end else if (cmd_r.op == CIS_SKIP_IF_BIT_SET_OP && isSkipSet) begin
          state_nxt = CIS_NOP2;
        end else begin
          state_nxt = CIS_IDLE;
        end
      end
      CIS_NOP2: state_nxt = CIS_IDLE;
      CIS_SLEEP: begin
        if (apbWr && paddr == CIS_OFF_WAKE && pwdata[0]) begin
          state_nxt = CIS_IDLE;
        end
      end
      default: state_nxt = CIS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= CIS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // (RULE1) discard the following instruction
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      skipPending_r <= 1'b0;
    end else if (state_r == CIS_EXEC && cmd_r.op == CIS_SKIP_IF_BIT_SET_OP) begin
      skipPending_r <= isSkipSet;
    end else if (state_r == CIS_IDLE && apbWr && paddr == CIS_OFF_CMD) begin
      skipPending_r <= 1'b0;
    end
  end

  // no-op slot of a discarded command
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      discard_r <= 1'b0;
    end else begin
      discard_r <= (state_r == CIS_IDLE) && (state_nxt == CIS_NOP2);
    end
  end

  // (RULE3) call loads pc and pushes return
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pc_r <= CIS_RST_PC;
      stackTop_r <= CIS_RST_PC;
    end else if (state_r == CIS_EXEC && cmd_r.op == CIS_CALL_OP) begin
      stackTop_r <= pc_r + 13'h0001;
      pc_r <= {pcHighLatch_r[4:3], cmd_r.k};
    end else if (state_r == CIS_EXEC || (state_r == CIS_NOP2 && discard_r)) begin
      pc_r <= pc_r + 13'h0001;
    end
  end

  // (RULE2) watchdog and prescaler clear pulse
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wdPulse_r <= 1'b0;
    end else begin
      wdPulse_r <= state_r == CIS_EXEC &&
                    (cmd_r.op == CIS_WATCHDOG_CLEAR_OP || cmd_r.op == CIS_SLEEP_OP);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  skip_nop_a : assert property ( // (RULE1)
    state_r == CIS_EXEC && cmd_r.op == CIS_SKIP_IF_BIT_SET_OP && isSkipSet
    |=> state_r == CIS_NOP2 && $stable(flags_r) ##1 state_r == CIS_IDLE && skipPending_r)
    else $error("skip did not insert a no-op");

  watchdog_clear_a : assert property ( // (RULE2)
    state_r == CIS_EXEC && cmd_r.op == CIS_WATCHDOG_CLEAR_OP
    |=> flags_r.timeoutFlag && flags_r.powerdownFlag && watchdogClear)
    else $error("watchdog clear flags wrong");

  call_load_a : assert property ( // (RULE3)
    state_r == CIS_EXEC && cmd_r.op == CIS_CALL_OP
    |=> pc_r == {$past(pcHighLatch_r[4:3]), $past(cmd_r.k)} &&
        stackTop_r == $past(pc_r) + 13'h0001 && $stable(flags_r))
    else $error("call target or return wrong");

  invert_result_a : assert property ( // (RULE4)
    state_r == CIS_EXEC && cmd_r.op == CIS_COMPLEMENT_FILE_OP && !cmd_r.dest
    |=> working_r == ~$past(fileVal) && flags_r.zeroFlag == ($past(fileVal) == 8'hff))
    else $error("complement result wrong");

  clear_file_a : assert property ( // (RULE5)
    state_r == CIS_EXEC && cmd_r.op == CIS_CLEAR_FILE_OP
    |-> ramWe && ramWdata == 8'h00 ##1 flags_r.zeroFlag)
    else $error("clear file wrong");

  clear_working_a : assert property ( // (RULE6)
    state_r == CIS_EXEC && cmd_r.op == CIS_CLEAR_WORKING_OP
    |=> working_r == 8'h00 && flags_r.zeroFlag)
    else $error("clear working wrong");

  decrement_file_a : assert property ( // (RULE7)
    state_r == CIS_EXEC && cmd_r.op == CIS_DECREMENT_FILE_OP && cmd_r.dest
    |-> ramWe && ramWdata == fileVal - 8'h01 && $stable(working_r))
    else $error("decrement to file wrong");

  rotate_left_a : assert property ( // (RULE8)
    state_r == CIS_EXEC && cmd_r.op == CIS_ROTATE_LEFT_CARRY_OP && !cmd_r.dest
    |=> working_r == {$past(fileVal[6:0]), $past(flags_r.carryFlag)} &&
        flags_r.carryFlag == $past(fileVal[7]))
    else $error("rotate left wrong");

  rotate_right_a : assert property ( // (RULE9)
    state_r == CIS_EXEC && cmd_r.op == CIS_ROTATE_RIGHT_CARRY_OP && !cmd_r.dest
    |=> working_r == {$past(flags_r.carryFlag), $past(fileVal[7:1])} &&
        flags_r.carryFlag == $past(fileVal[0]))
    else $error("rotate right wrong");

  sleep_halt_a : assert property ( // (RULE10)
    state_r == CIS_EXEC && cmd_r.op == CIS_SLEEP_OP
    |=> oscStop && watchdogClear && flags_r.timeoutFlag && !flags_r.powerdownFlag)
    else $error("sleep entry wrong");

  literal_sub_a : assert property ( // (RULE11)
    state_r == CIS_EXEC && cmd_r.op == CIS_LITERAL_SUBTRACT_OP
    |=> working_r == $past(cmd_r.k[7:0]) - $past(working_r) &&
        flags_r.carryFlag == ($past(working_r) <= $past(cmd_r.k[7:0])))
    else $error("literal subtract wrong");

  zero_flag_a : assert property ( // (RULE12)
    state_r == CIS_EXEC && cmd_r.op == CIS_DECREMENT_FILE_OP && !cmd_r.dest
    |=> flags_r.zeroFlag == (working_r == 8'h00))
    else $error("zero flag disagrees with result");

endmodule : cis_core
`default_nettype wire

// ---- bench/tb_core_instruction_subset.sv ----
// self-checking bench for the core instruction subset block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin errCount++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_core_instruction_subset
  import cis_pkg::*;
;
  typedef struct {
    cis_op_e    op;
    logic       dest;
    logic [2:0] bitSel;
    logic [6:0] fAddr;
    logic [7:0] k;
    logic [7:0] wIn;
    logic [7:0] fIn;
    logic [7:0] wExp;
    logic [7:0] fExp;
    logic [4:0] flagsExp;
  } cis_row_s;

  logic        ref_clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        watchdogClear;
  logic        oscStop;
  logic [31:0] rdVal;
  logic        rdErr;
  int          errCount = 0;
  int          samplesChecked = 0;
  int          cycles = 0;
  int          wdCount = 0;

  // op, dest, bit, file addr, literal, w in, f in, w out, f out, flags out
  cis_row_s rows [16] = '{
    '{CIS_COMPLEMENT_FILE_OP,    1'b0, 3'h0, 7'h05, 8'h00, 8'h00, 8'h5a, 8'ha5, 8'h5a, 5'h18},
    '{CIS_COMPLEMENT_FILE_OP,    1'b1, 3'h0, 7'h05, 8'h00, 8'h33, 8'hff, 8'h33, 8'h00, 5'h1c},
    '{CIS_DECREMENT_FILE_OP,     1'b0, 3'h0, 7'h7f, 8'h00, 8'h44, 8'h01, 8'h00, 8'h01, 5'h1c},
    '{CIS_DECREMENT_FILE_OP,     1'b1, 3'h0, 7'h7f, 8'h00, 8'h44, 8'h00, 8'h44, 8'hff, 5'h18},
    '{CIS_ROTATE_LEFT_CARRY_OP,  1'b0, 3'h0, 7'h10, 8'h00, 8'h00, 8'he6, 8'hcc, 8'he6, 5'h19},
    '{CIS_ROTATE_LEFT_CARRY_OP,  1'b1, 3'h0, 7'h10, 8'h00, 8'h12, 8'h01, 8'h12, 8'h03, 5'h18},
    '{CIS_ROTATE_RIGHT_CARRY_OP, 1'b1, 3'h0, 7'h10, 8'h00, 8'h55, 8'h01, 8'h55, 8'h00, 5'h19},
    '{CIS_ROTATE_RIGHT_CARRY_OP, 1'b0, 3'h0, 7'h10, 8'h00, 8'h00, 8'h80, 8'hc0, 8'h80, 5'h18},
    '{CIS_CLEAR_FILE_OP,         1'b0, 3'h0, 7'h20, 8'h00, 8'h77, 8'haa, 8'h77, 8'h00, 5'h1c},
    '{CIS_CLEAR_WORKING_OP,      1'b0, 3'h0, 7'h20, 8'h00, 8'hab, 8'h11, 8'h00, 8'h11, 5'h1c},
    '{CIS_LITERAL_SUBTRACT_OP,   1'b0, 3'h0, 7'h20, 8'h05, 8'h03, 8'h22, 8'h02, 8'h22, 5'h1b},
    '{CIS_LITERAL_SUBTRACT_OP,   1'b0, 3'h0, 7'h20, 8'h03, 8'h05, 8'h22, 8'hfe, 8'h22, 5'h18},
    '{CIS_LITERAL_SUBTRACT_OP,   1'b0, 3'h0, 7'h20, 8'h10, 8'h10, 8'h22, 8'h00, 8'h22, 5'h1f},
    '{CIS_LITERAL_SUBTRACT_OP,   1'b0, 3'h0, 7'h20, 8'h10, 8'h01, 8'h22, 8'h0f, 8'h22, 5'h19},
    '{CIS_WATCHDOG_CLEAR_OP,     1'b0, 3'h0, 7'h20, 8'h00, 8'h66, 8'h22, 8'h66, 8'h22, 5'h19},
    '{CIS_SKIP_IF_BIT_SET_OP,    1'b0, 3'h3, 7'h20, 8'h00, 8'h66, 8'hf7, 8'h66, 8'hf7, 5'h19}
  };

  logic [7:0]  rstAddr [6] = '{CIS_OFF_STATUS, CIS_OFF_WORK, CIS_OFF_PC, CIS_OFF_LATCH, CIS_OFF_STACK, CIS_OFF_FADDR};
  logic [31:0] rstExp  [6] = '{32'h0000_0018, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  cis_core u_cis_core (
    .ref_clk       (ref_clk),
    .reset         (reset),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .watchdogClear (watchdogClear),
    .oscStop       (oscStop)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // pulses that clear the watchdog
  always @(posedge ref_clk) begin
    if (reset === 1'b0 && watchdogClear === 1'b1) begin
      wdCount++;
    end
  end

  task automatic closeOut();
    $display("checks=%0d errors=%0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : closeOut

  initial begin
    forever begin
      @(posedge ref_clk);
      cycles++;
      if (cycles == 5000) begin
        errCount++;
        closeOut();
      end
    end
  end

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rdVal = prdata;
    rdErr = pslverr;
    if (n >= 64) begin
      errCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, pready, 1'b1);
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic exec(input cis_op_e op, input logic dest, input logic [2:0] b, input logic [6:0] fa,
                      input logic [10:0] k);
    cis_cmd_s c;
    c = '{k: k, fAddr: fa, bitSel: b, dest: dest, op: op};
    apb(1'b1, CIS_OFF_CMD, {6'h00, c});
  endtask : exec

  initial begin
    reset   = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, rstAddr[i], 32'h0);
      `CHK(rdVal, rstExp[i]) // reset values
    end
    apb(1'b0, 8'h24, 32'h0);
    `CHK({rdErr, rdVal}, {1'b1, 32'h0}) // unmapped read
    apb(1'b1, CIS_OFF_STATUS, 32'h0000_00ff);
    apb(1'b0, CIS_OFF_STATUS, 32'h0);
    `CHK(rdVal, 32'h0000_0018) // read-only status
    apb(1'b1, CIS_OFF_LATCH, 32'h0000_0018);
    exec(CIS_CALL_OP, 1'b0, 3'h0, 7'h00, 11'h2a5);
    apb(1'b0, CIS_OFF_PC, 32'h0);
    `CHK(rdVal, 32'h0000_1aa5)
    apb(1'b0, CIS_OFF_STACK, 32'h0);
    `CHK(rdVal, 32'h0000_0001)
    apb(1'b0, CIS_OFF_STATUS, 32'h0);
    `CHK(rdVal, 32'h0000_0018)
    // taken skip discards the next command
    apb(1'b1, CIS_OFF_FADDR, 32'h0000_0030);
    apb(1'b1, CIS_OFF_FDATA, 32'h0000_0008);
    apb(1'b1, CIS_OFF_WORK, 32'h0000_005a);
    exec(CIS_SKIP_IF_BIT_SET_OP, 1'b0, 3'h3, 7'h30, 11'h000);
    apb(1'b0, CIS_OFF_STATUS, 32'h0);
    `CHK(rdVal, 32'h0000_0098)
    exec(CIS_CLEAR_WORKING_OP, 1'b0, 3'h0, 7'h00, 11'h000);
    apb(1'b0, CIS_OFF_WORK, 32'h0);
    `CHK(rdVal, 32'h0000_005a)
    apb(1'b0, CIS_OFF_PC, 32'h0);
    `CHK(rdVal, 32'h0000_1aa7)
    apb(1'b0, CIS_OFF_STATUS, 32'h0);
    `CHK(rdVal, 32'h0000_0018)
    // table of data operations
    foreach (rows[i]) begin
      apb(1'b1, CIS_OFF_WORK, {24'h0, rows[i].wIn});
      apb(1'b1, CIS_OFF_FADDR, {25'h0, rows[i].fAddr});
      apb(1'b1, CIS_OFF_FDATA, {24'h0, rows[i].fIn});
      exec(rows[i].op, rows[i].dest, rows[i].bitSel, rows[i].fAddr, {3'h0, rows[i].k});
      apb(1'b0, CIS_OFF_WORK, 32'h0);
      `CHK(rdVal, {24'h0, rows[i].wExp})
      apb(1'b0, CIS_OFF_FDATA, 32'h0);
      `CHK(rdVal, {24'h0, rows[i].fExp})
      apb(1'b0, CIS_OFF_STATUS, 32'h0);
      `CHK(rdVal, {27'h0, rows[i].flagsExp})
    end
    `CHK(wdCount, 1)
    exec(CIS_SLEEP_OP, 1'b0, 3'h0, 7'h00, 11'h000);
    apb(1'b0, CIS_OFF_STATUS, 32'h0);
    `CHK(rdVal, 32'h0000_0051)
    `CHK(oscStop, 1'b1)
    `CHK(wdCount, 2)
    exec(CIS_CLEAR_WORKING_OP, 1'b0, 3'h0, 7'h00, 11'h000);
    apb(1'b1, CIS_OFF_WAKE, 32'h0000_0001);
    apb(1'b0, CIS_OFF_WORK, 32'h0);
    `CHK(rdVal, 32'h0000_0066)
    `CHK(oscStop, 1'b0)
    exec(CIS_WATCHDOG_CLEAR_OP, 1'b0, 3'h0, 7'h00, 11'h000);
    apb(1'b0, CIS_OFF_STATUS, 32'h0);
    `CHK(rdVal, 32'h0000_0019)
    `CHK(wdCount, 3)
    closeOut();
  end
endmodule : tb_core_instruction_subset
`undef CHK
`default_nettype wire
